// ### hw/ext_irq_pkg.sv
package ext_irq_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SYSCTL = 8'h35;
   localparam logic [7:0] IDX_FLAG = 8'h3A;
   localparam logic [7:0] IDX_MASK = 8'h3B;
   localparam logic [7:0] IDX_STATUS = 8'h3C;
   localparam int ADDR_W = 12;

   localparam logic [7:0] SYSCTL_RESET = 8'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] FLAG_RESET = 2'h0;

   // system_control fields
   localparam int BIT_XMEM_EN = 7;
   localparam int BIT_XMEM_WAIT = 6;
   localparam int BIT_SLEEP_ARM = 5;
   localparam int BIT_SLEEP_TYPE = 4;
   localparam int SENSE_B_LSB = 2;
   localparam int SENSE_A_LSB = 0;

   // flag and mask registers: pin b at bit 7, pin a at bit 6
   localparam int BIT_PIN_B = 7;
   localparam int BIT_PIN_A = 6;

   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_RSVD = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   localparam logic [3:0] VEC_A = 4'h1;
   localparam logic [3:0] VEC_B = 4'h2;

   localparam logic [2:0] ENTRY_CYCLES = 3'h4;
   localparam logic [2:0] JUMP_CYCLES = 3'h2;
   localparam logic [2:0] RETURN_CYCLES = 3'h4;
   localparam logic [2:0] PC_BYTES = 3'h2;

   localparam logic [1:0] XMEM_CYCLES_NORMAL = 2'h2;
   localparam logic [1:0] XMEM_CYCLES_WAIT = 2'h3;

   localparam int CLK_HZ = 125000000;
   localparam int OSC_STARTUP_MS = 16;
   localparam int OSC_STARTUP_CYCLES = OSC_STARTUP_MS * (CLK_HZ / 1000);
   localparam int STARTUP_W = 21;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_SYSCTL = 3'h1;
   localparam logic [2:0] SEL_FLAG = 3'h2;
   localparam logic [2:0] SEL_MASK = 3'h3;
   localparam logic [2:0] SEL_STATUS = 3'h4;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_ENTRY,
      ST_JUMP,
      ST_RETURN,
      ST_POSTRET,
      ST_IDLE,
      ST_PDOWN,
      ST_WAKEUP
   } cpu_state_e;

endpackage

// ### hw/ext_sense.sv
`timescale 1ns/1ps
`default_nettype none
module ext_sense
   import ext_irq_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic [1:0] sense,
   input wire logic freeze,
   output logic edge_ev_ff,
   output logic level_req_ff
);

   logic prev_ff;

   // idle level of an unconnected pin is high, so a low pin at reset release counts as a falling edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= pin;
      end
   end

   // the pin is read back whatever its direction, so writing it as an output also triggers
   // a sense change alone never looks like an edge, as prev_ff follows the pin in every mode; software masks the pin first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_ev_ff <= 1'b0;
         level_req_ff <= 1'b0;
      end else begin
         edge_ev_ff <= 1'b0;
         level_req_ff <= 1'b0;
         case (sense)
            SENSE_LOW: level_req_ff <= ~pin;
            SENSE_FALL: edge_ev_ff <= prev_ff & ~pin & ~freeze;
            SENSE_RISE: edge_ev_ff <= ~prev_ff & pin & ~freeze;
            default: begin
               edge_ev_ff <= 1'b0;
               level_req_ff <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### hw/ext_irq_sleep_control.sv
// Summary of operation
// - pin activity triggers an enabled external interrupt even when the pin is an output.
// - low-level sensing keeps requesting while the pin stays low.
// - entry takes four cycles, pushes two PC bytes, stack pointer drops by two.
// - the vector is a relative jump taking two cycles.
// - entry starts only after the current instruction completes.
// - return takes four cycles, pops two PC bytes, stack pointer rises by two.
// - after return one main-program instruction runs before a pending interrupt.
// - edge flags set only on the event, stay clear while the condition persists.
// - external memory enable gives the bus pins alternate functions, overriding directions.
// - external memory wait bit adds one wait cycle to each access.
// - sleep instruction sleeps only when sleep arm is set.
// - sleep type zero selects idle, one selects power-down.
// - pin b sense field: low level, reserved, falling, rising.
// - pin a sense field uses the same encoding.
// - enabled interrupt wakes from idle, enabled low level from power-down; runs handler, resumes after the sleep.
// - reset during sleep wakes the device to the reset vector.
// - idle stops the CPU; timers, watchdog and interrupts keep running.
// - power-down stops oscillator; wake by watchdog, reset or level interrupt only.
// - external flags set by pin events, cleared at vector or by writing one.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sleep_control
   import ext_irq_pkg::*;
#(
   parameter int STARTUP_CYCLES = OSC_STARTUP_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic core_irq_enable,
   input wire logic core_instr_end,
   input wire logic core_sleep_exec,
   input wire logic core_reti_exec,
   input wire logic int_irq_req,
   input wire logic [3:0] int_irq_vector,
   input wire logic wdt_enabled,
   input wire logic wdt_timeout,
   input wire logic [7:0] ddr_ad,
   input wire logic [7:0] ddr_addr_hi,
   input wire logic [1:0] ddr_strobe,
   input wire logic xmem_ad_drive,
   output logic core_hold_ff,
   output logic stack_push_ff,
   output logic stack_pop_ff,
   output logic pc_byte_sel_ff,
   output logic vector_valid_ff,
   output logic [3:0] vector_addr_ff,
   output logic vector_jump_ff,
   output logic int_irq_ack_ff,
   output logic osc_stop_ff,
   output logic wake_ff,
   output logic alt_fn_ff,
   output logic [7:0] dir_ad_ff,
   output logic [7:0] dir_addr_hi_ff,
   output logic [1:0] dir_strobe_ff,
   output logic xmem_wait_ff,
   output logic [1:0] xmem_cycles_ff
);

   logic [7:0] sysctl_ff;
   logic [1:0] mask_ff;
   logic [1:0] flag_ff;
   logic [1:0] nxt_flag;
   logic [1:0] edge_ev;
   logic [1:0] level_req;
   logic [1:0] pins;
   logic [1:0] req;
   logic any_req;
   logic take;
   logic pd_wake;
   cpu_state_e state_ff;
   logic [2:0] cnt_ff;
   logic [3:0] vec_ff;
   logic [STARTUP_W-1:0] startup_ff;
   logic aw_held_ff;
   logic w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_fire;
   logic [2:0] wr_sel;
   logic [7:0] status;
   logic [7:0] rd_byte;
   logic [2:0] rd_sel;

   localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(STARTUP_CYCLES - 1);

   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_SYSCTL)) begin
         reg_sel = SEL_SYSCTL;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_FLAG)) begin
         reg_sel = SEL_FLAG;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MASK)) begin
         reg_sel = SEL_MASK;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_STATUS)) begin
         reg_sel = SEL_STATUS;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

   // fixed priority: pin a, then pin b, then the internal sources
   function automatic logic [3:0] prio_vec(input logic [1:0] r, input logic ir, input logic [3:0] iv);
      if (r[0]) begin
         prio_vec = VEC_A;
      end else if (r[1]) begin
         prio_vec = VEC_B;
      end else begin
         prio_vec = ir ? iv : 4'h0;
      end
   endfunction

   assign pins = {ext_irq_pin_b, ext_irq_pin_a};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sense
         ext_sense u_sense (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(pins[gi]),
            .sense(sysctl_ff[2*gi+1 -: 2]),
            .freeze(state_ff == ST_PDOWN),
            .edge_ev_ff(edge_ev[gi]),
            .level_req_ff(level_req[gi])
         );
      end
   endgenerate

   // ---------------- register bus ----------------
   assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
   assign wr_sel = reg_sel(awaddr_ff);
   assign rd_sel = reg_sel(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_ff <= '0;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_held_ff <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_ff <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_ff & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_held_ff <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_ff <= 1'b0;
      end else begin
         s_axi_wready <= ~w_held_ff & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign status = {req, level_req, state_ff == ST_POSTRET, state_ff == ST_PDOWN,
                    state_ff == ST_IDLE || state_ff == ST_PDOWN || state_ff == ST_WAKEUP, core_hold_ff};

   always_comb begin
      rd_byte = 8'h00;
      if (rd_sel == SEL_SYSCTL) begin
         rd_byte = sysctl_ff;
      end else if (rd_sel == SEL_FLAG) begin
         rd_byte = {flag_ff[1], flag_ff[0], 6'h00};
      end else if (rd_sel == SEL_MASK) begin
         rd_byte = {mask_ff[1], mask_ff[0], 6'h00};
      end else if (rd_sel == SEL_STATUS) begin
         rd_byte = status;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysctl_ff <= SYSCTL_RESET;
      end else if (wr_fire && wr_sel == SEL_SYSCTL && wstrb_ff[0]) begin
         sysctl_ff <= wdata_ff[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_ff <= MASK_RESET;
      end else if (wr_fire && wr_sel == SEL_MASK && wstrb_ff[0]) begin
         mask_ff <= {wdata_ff[BIT_PIN_B], wdata_ff[BIT_PIN_A]};
      end
   end

   // ---------------- flags and requests ----------------
   always_comb begin
      nxt_flag = flag_ff;
      for (int k = 0; k < 2; k++) begin
         if (wr_fire && wr_sel == SEL_FLAG && wstrb_ff[0] && wdata_ff[BIT_PIN_A + k]) begin
            nxt_flag[k] = 1'b0;
         end
         if (state_ff == ST_ENTRY && cnt_ff == ENTRY_CYCLES - 3'h1 && vec_ff == (k == 0 ? VEC_A : VEC_B)) begin
            nxt_flag[k] = 1'b0;
         end
         // only the edge event sets the flag, and it wins over a clear in the same cycle
         if (edge_ev[k]) begin
            nxt_flag[k] = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ff <= FLAG_RESET;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign req = mask_ff & (flag_ff | level_req);
   assign any_req = (|req) | int_irq_req;
   assign take = core_irq_enable & any_req;
   // with the oscillator stopped only a low level or the watchdog can wake
   assign pd_wake = (core_irq_enable & |(mask_ff & level_req)) | (wdt_enabled & wdt_timeout);

   // ---------------- entry, return and sleep sequencing ----------------
   // the CPU status register is never stacked here; the handler saves it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_RUN;
         cnt_ff <= 3'h0;
         vec_ff <= 4'h0;
         startup_ff <= '0;
      end else begin
         case (state_ff)
            ST_RUN: begin
               cnt_ff <= 3'h0;
               if (core_sleep_exec && sysctl_ff[BIT_SLEEP_ARM]) begin
                  state_ff <= sysctl_ff[BIT_SLEEP_TYPE] ? ST_PDOWN : ST_IDLE;
               end else if (core_reti_exec) begin
                  state_ff <= ST_RETURN;
               end else if (core_instr_end && take) begin
                  state_ff <= ST_ENTRY;
                  vec_ff <= prio_vec(req, int_irq_req, int_irq_vector);
               end
            end
            ST_ENTRY: begin
               if (cnt_ff == ENTRY_CYCLES - 3'h1) begin
                  state_ff <= ST_JUMP;
                  cnt_ff <= 3'h0;
               end else begin
                  cnt_ff <= cnt_ff + 3'h1;
               end
            end
            ST_JUMP: begin
               if (cnt_ff == JUMP_CYCLES - 3'h1) begin
                  state_ff <= ST_RUN;
                  cnt_ff <= 3'h0;
               end else begin
                  cnt_ff <= cnt_ff + 3'h1;
               end
            end
            ST_RETURN: begin
               if (cnt_ff == RETURN_CYCLES - 3'h1) begin
                  state_ff <= ST_POSTRET;
                  cnt_ff <= 3'h0;
               end else begin
                  cnt_ff <= cnt_ff + 3'h1;
               end
            end
            ST_POSTRET: begin
               if (core_instr_end) begin
                  state_ff <= ST_RUN;
               end
            end
            ST_IDLE: begin
               if (take) begin
                  state_ff <= ST_ENTRY;
                  cnt_ff <= 3'h0;
                  vec_ff <= prio_vec(req, int_irq_req, int_irq_vector);
               end
            end
            ST_PDOWN: begin
               startup_ff <= '0;
               if (pd_wake) begin
                  state_ff <= ST_WAKEUP;
               end
            end
            ST_WAKEUP: begin
               if (startup_ff == STARTUP_LAST) begin
                  // a level that has gone away by now is simply lost
                  if (take) begin
                     state_ff <= ST_ENTRY;
                     cnt_ff <= 3'h0;
                     vec_ff <= prio_vec(req, int_irq_req, int_irq_vector);
                  end else begin
                     state_ff <= ST_RUN;
                  end
               end else begin
                  startup_ff <= startup_ff + STARTUP_W'(1);
               end
            end
            default: state_ff <= ST_RUN;
         endcase
      end
   end

   // core strobes are decoded from the state one cycle late, so they all come from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_hold_ff <= 1'b0;
         stack_push_ff <= 1'b0;
         stack_pop_ff <= 1'b0;
         pc_byte_sel_ff <= 1'b0;
         vector_valid_ff <= 1'b0;
         vector_addr_ff <= 4'h0;
         vector_jump_ff <= 1'b0;
         int_irq_ack_ff <= 1'b0;
      end else begin
         core_hold_ff <= state_ff != ST_RUN && state_ff != ST_POSTRET;
         stack_push_ff <= state_ff == ST_ENTRY && cnt_ff < PC_BYTES;
         stack_pop_ff <= state_ff == ST_RETURN && cnt_ff < PC_BYTES;
         pc_byte_sel_ff <= cnt_ff[0];
         vector_valid_ff <= state_ff == ST_ENTRY && cnt_ff == ENTRY_CYCLES - 3'h1;
         vector_addr_ff <= vec_ff;
         vector_jump_ff <= state_ff == ST_JUMP;
         int_irq_ack_ff <= state_ff == ST_ENTRY && cnt_ff == ENTRY_CYCLES - 3'h1 &&
                           vec_ff != VEC_A && vec_ff != VEC_B;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_stop_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         osc_stop_ff <= state_ff == ST_PDOWN;
         wake_ff <= (state_ff == ST_IDLE && take) || (state_ff == ST_PDOWN && pd_wake);
      end
   end

   // ---------------- external memory pin control ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alt_fn_ff <= 1'b0;
         dir_ad_ff <= 8'h00;
         dir_addr_hi_ff <= 8'h00;
         dir_strobe_ff <= 2'h0;
      end else if (sysctl_ff[BIT_XMEM_EN]) begin
         alt_fn_ff <= 1'b1;
         dir_ad_ff <= {8{xmem_ad_drive}};
         dir_addr_hi_ff <= 8'hFF;
         dir_strobe_ff <= 2'h3;
      end else begin
         alt_fn_ff <= 1'b0;
         dir_ad_ff <= ddr_ad;
         dir_addr_hi_ff <= ddr_addr_hi;
         dir_strobe_ff <= ddr_strobe;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xmem_wait_ff <= 1'b0;
         xmem_cycles_ff <= XMEM_CYCLES_NORMAL;
      end else begin
         xmem_wait_ff <= sysctl_ff[BIT_XMEM_WAIT];
         xmem_cycles_ff <= sysctl_ff[BIT_XMEM_WAIT] ? XMEM_CYCLES_WAIT : XMEM_CYCLES_NORMAL;
      end
   end

endmodule
`default_nettype wire

// ### verif/ext_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
   input wire logic aclk,
   input wire logic [1:0] want,
   output logic pin_a,
   output logic pin_b
);
   // the sources are synchronous drivers: levels move only just after an edge
   initial begin
      pin_a = 1'b1;
      pin_b = 1'b1;
   end
   always @(posedge aclk) begin
      pin_a <= want[0];
      pin_b <= want[1];
   end
endmodule
`default_nettype wire

// ### verif/ext_irq_sleep_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sleep_control_sva #(
   parameter int STARTUP_CYCLES = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_instr_end,
   input wire logic core_hold_ff,
   input wire logic stack_push_ff,
   input wire logic stack_pop_ff,
   input wire logic pc_byte_sel_ff,
   input wire logic vector_valid_ff,
   input wire logic vector_jump_ff,
   input wire logic osc_stop_ff,
   input wire logic wake_ff,
   input wire logic xmem_wait_ff,
   input wire logic [1:0] xmem_cycles_ff
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_push_two_bytes: assert property ($rose(stack_push_ff) |-> !pc_byte_sel_ff ##1 stack_push_ff && pc_byte_sel_ff ##1 !stack_push_ff)
      else $error("push sequence wrong");
   a_entry_length: assert property ($rose(stack_push_ff) |-> ##3 vector_valid_ff ##1 vector_jump_ff)
      else $error("entry length wrong");
   a_jump_two: assert property ($rose(vector_jump_ff) |-> vector_jump_ff[*2] ##1 !vector_jump_ff)
      else $error("jump length wrong");
   a_pop_two_bytes: assert property ($rose(stack_pop_ff) |-> stack_pop_ff[*2] ##1 !stack_pop_ff)
      else $error("pop sequence wrong");
   a_return_length: assert property ($rose(stack_pop_ff) |-> core_hold_ff[*4] ##1 !core_hold_ff)
      else $error("return length wrong");
   // entry from run needs a finished instruction; from sleep the core is already held
   a_entry_after_instr: assert property ($rose(stack_push_ff) |-> $past(core_instr_end, 2) || $past(core_hold_ff, 2))
      else $error("entry before instruction end");
   a_wait_cycles: assert property ($rose(xmem_wait_ff) |-> ##[0:2] xmem_cycles_ff == 2'h3)
      else $error("wait cycle missing");
   a_wake_pulse: assert property (wake_ff |=> !wake_ff)
      else $error("wake not a pulse");
   a_pdown_stalls: assert property (osc_stop_ff |-> core_hold_ff)
      else $error("core runs in power-down");
   c_entry: cover property (vector_valid_ff);
   c_return: cover property ($rose(stack_pop_ff));
   c_pdown_wake: cover property (wake_ff && osc_stop_ff ##1 $fell(osc_stop_ff));
endmodule
bind ext_irq_sleep_control ext_irq_sleep_control_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) ext_irq_sleep_control_sva_i (
   .aclk(aclk), .aresetn(aresetn), .core_instr_end(core_instr_end), .core_hold_ff(core_hold_ff),
   .stack_push_ff(stack_push_ff), .stack_pop_ff(stack_pop_ff), .pc_byte_sel_ff(pc_byte_sel_ff),
   .vector_valid_ff(vector_valid_ff), .vector_jump_ff(vector_jump_ff), .osc_stop_ff(osc_stop_ff),
   .wake_ff(wake_ff), .xmem_wait_ff(xmem_wait_ff), .xmem_cycles_ff(xmem_cycles_ff)
);
`default_nettype wire

// ### verif/tb_ext_irq_sleep_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ext_irq_sleep_control
   import ext_irq_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, q;
   logic [1:0] rs, want = 2'h3;
   logic [2:0] ev = 3'h0;
   logic irq_en = 0, int_req = 0, wdt_en = 0, wdt_to = 0, xd = 0;
   logic [7:0] ddr_ad = 8'h5A;
   wire logic awready, wready, bvalid, arready, rvalid, pa, pb, hold, push, pop, vv, wake, osc, alt, xw, ack;
   wire logic [1:0] bresp, rresp, xc, dst;
   wire logic [31:0] rdata;
   wire logic [3:0] va;
   wire logic [7:0] dad, dah;
   wire logic [2:0] obs = {wake, pop, vv};
   int n_fail = 0, compares = 0, cyc = 0, n_vec = 0, n_ack = 0, p, s;

   ext_pin_source ext_pin_source_i (.aclk(aclk), .want(want), .pin_a(pa), .pin_b(pb));
   ext_irq_sleep_control #(.STARTUP_CYCLES(8)) ext_irq_sleep_control_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_pin_a(pa), .ext_irq_pin_b(pb),
      .core_irq_enable(irq_en), .core_instr_end(ev[0]), .core_sleep_exec(ev[1]), .core_reti_exec(ev[2]),
      .int_irq_req(int_req), .int_irq_vector(4'h5), .wdt_enabled(wdt_en), .wdt_timeout(wdt_to),
      .ddr_ad(ddr_ad), .ddr_addr_hi(ddr_ad), .ddr_strobe(2'h1), .xmem_ad_drive(xd), .core_hold_ff(hold),
      .stack_push_ff(push), .stack_pop_ff(pop), .pc_byte_sel_ff(), .vector_valid_ff(vv), .vector_addr_ff(va),
      .vector_jump_ff(), .int_irq_ack_ff(ack), .osc_stop_ff(osc), .wake_ff(wake), .alt_fn_ff(alt),
      .dir_ad_ff(dad), .dir_addr_hi_ff(dah), .dir_strobe_ff(dst), .xmem_wait_ff(xw), .xmem_cycles_ff(xc)
   );

   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (vv === 1'b1) n_vec <= n_vec + 1;
      if (ack === 1'b1) n_ack <= n_ack + 1;
      if (cyc == 6000) begin
         n_fail++;
         end_of_test;
      end
   end

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // readies are sampled at the falling edge, where they are settled for the next rising edge
   task automatic axi(input bit wr, input logic [7:0] idx, input logic [7:0] d);
      logic a, w, x, r;
      r = 0;
      @(posedge aclk);
      if (wr) begin
         awaddr <= {2'h0, idx, 2'h0};
         wdata <= {24'h0, d};
         awvalid <= 1;
         wvalid <= 1;
         bready <= 1;
      end else begin
         araddr <= {2'h0, idx, 2'h0};
         arvalid <= 1;
         rready <= 1;
      end
      while (!r) begin
         @(negedge aclk);
         a = awvalid && awready;
         w = wvalid && wready;
         x = arvalid && arready;
         r = wr ? bvalid && bready : rvalid && rready;
         q = rdata;
         rs = wr ? bresp : rresp;
         @(posedge aclk);
         if (a) awvalid <= 0;
         if (w) wvalid <= 0;
         if (x) arvalid <= 0;
      end
      bready <= 0;
      rready <= 0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      axi(1, idx, d);
      check(rs, RESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      axi(0, idx, 8'h0);
      check(q, exp);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge aclk);
      ev <= v;
      @(posedge aclk);
      ev <= 3'h0;
   endtask
   task automatic wait_hi(input int b);
      int i;
      i = 0;
      do tick(1); while (obs[b] !== 1'b1 && ++i < 40);
      check(obs[b], 1'b1);
   endtask
   task automatic rst;
      @(posedge aclk);
      aresetn <= 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      tick(2);
   endtask

   initial begin
      rst;
      rd(IDX_SYSCTL, {24'h0, SYSCTL_RESET});
      rd(IDX_FLAG, 32'h0);
      axi(0, 8'h20, 8'h0);
      check(rs, RESP_SLVERR);
      ddr_ad <= 8'hA5;
      xd <= 1;
      wr(IDX_SYSCTL, 8'hC0);
      tick(3);
      check(alt, 1'b1);
      check(xc, XMEM_CYCLES_WAIT);
      check({dst, dah, dad}, 18'h3FFFF);
      wr(IDX_SYSCTL, 8'h00);
      tick(3);
      check(alt, 1'b0);
      check({dst, dah, dad}, {2'h1, 16'hA5A5});
      check(xc, XMEM_CYCLES_NORMAL);
      for (p = 0; p < 2; p++) begin
         for (s = 0; s < 4; s++) begin
            wr(IDX_MASK, 8'h00);
            wr(IDX_SYSCTL, 8'(s << (2 * p)));
            wr(IDX_MASK, 8'(1 << (6 + p)));
            wr(IDX_FLAG, 8'hC0);
            want[p] <= 1'b0;
            tick(4);
            axi(0, IDX_STATUS, 8'h0);
            check(q[4 + p], s == 0);
            rd(IDX_FLAG, (s == 2) << (6 + p));
            want[p] <= 1'b1;
            tick(4);
            rd(IDX_FLAG, s[1] << (6 + p));
            wr(IDX_FLAG, 8'hC0);
            tick(4);
            rd(IDX_FLAG, 32'h0);
         end
      end
      irq_en <= 1;
      wr(IDX_MASK, 8'h00);
      wr(IDX_SYSCTL, 8'h00);
      wr(IDX_MASK, 8'h40);
      want <= 2'h2;
      tick(6);
      check(n_vec, 0);
      pulse(3'h1);
      wait_hi(0);
      check(va, VEC_A);
      tick(4);
      pulse(3'h4);
      wait_hi(1);
      tick(6);
      pulse(3'h1);
      tick(8);
      check(n_vec, 1);
      pulse(3'h1);
      wait_hi(0);
      want <= 2'h3;
      tick(8);
      pulse(3'h4);
      tick(8);
      pulse(3'h1);
      pulse(3'h2);
      tick(2);
      check(hold, 1'b0);
      wr(IDX_SYSCTL, 8'h20);
      pulse(3'h2);
      tick(2);
      check(hold, 1'b1);
      check(osc, 1'b0);
      int_req <= 1;
      wait_hi(2);
      wait_hi(0);
      check(va, 4'h5);
      int_req <= 0;
      tick(8);
      pulse(3'h4);
      tick(8);
      pulse(3'h1);
      wr(IDX_MASK, 8'h00);
      wr(IDX_SYSCTL, 8'h38);
      wr(IDX_MASK, 8'hC0);
      pulse(3'h2);
      tick(3);
      check(osc, 1'b1);
      want <= 2'h1;
      tick(12);
      check(osc, 1'b1);
      wdt_en <= 1;
      wdt_to <= 1;
      wait_hi(2);
      tick(1);
      check(osc, 1'b0);
      wdt_to <= 0;
      want <= 2'h3;
      tick(8);
      pulse(3'h2);
      tick(3);
      check(osc, 1'b1);
      // level held low well past start-up, so it still stands when the core resumes
      want <= 2'h2;
      wait_hi(2);
      wait_hi(0);
      check(va, VEC_A);
      rst;
      check(osc, 1'b0);
      check(hold, 1'b0);
      rd(IDX_SYSCTL, 32'h0);
      check(n_ack, 1);
      end_of_test;
   end
endmodule
`default_nettype wire
